//--- design/acm_defs.vh
`ifndef ACM_DEFS_VH
`define ACM_DEFS_VH

`define ACM_IDX_RESULT 3'h0
`define ACM_IDX_STATUS 3'h1
`define ACM_IDX_CONFIG 3'h2
`define ACM_IDX_LOWER 3'h3
`define ACM_IDX_UPPER 3'h4
`define ACM_IDX_HYST 3'h5
`define ACM_IDX_LOWEST 3'h6
`define ACM_IDX_HIGHEST 3'h7

`define ACM_CFG_CT_HI 7
`define ACM_CFG_CT_LO 5
`define ACM_CFG_HOLD 4
`define ACM_CFG_FLAG_EN 3
`define ACM_CFG_PIN_EN 2
`define ACM_CFG_QUIET 1
`define ACM_CFG_POL 0
`define ACM_ST_OVER 1
`define ACM_ST_UNDER 0

`define ACM_RST_CONFIG 8'h00
`define ACM_RST_LOWER 10'h000
`define ACM_RST_UPPER 10'h3ff
`define ACM_RST_HYST 10'h000
`define ACM_RST_LOWEST 10'h3ff
`define ACM_RST_HIGHEST 10'h000

`define ACM_CLK_MHZ 250
`define ACM_QUIET_KSPS 162
`define ACM_QUIET_GAP_CYC \
  ((`ACM_CLK_MHZ * 1000 + `ACM_QUIET_KSPS - 1) / `ACM_QUIET_KSPS)
`define ACM_CYCLE_BASE_US 32
`define ACM_CYCLE_BASE_CYC (`ACM_CYCLE_BASE_US * `ACM_CLK_MHZ)

`define ACM_AHB_MAP_TOP 27'h0000000
`define ACM_DEV_ADDR 7'h50

`endif

//--- design/acm_link.v
`timescale 1ns/1ps
`include "acm_defs.vh"
module acm_link #(
  parameter [6:0] DEV_ADDR = `ACM_DEV_ADDR
) (
  input wire clock_i, // System clock
  input wire rst_i, // Async reset, active high
  input wire scl_i, // Serial clock pin
  input wire sda_i, // Serial data pin level
  output wire sda_o, // Serial data drive level
  output reg sda_oe_o, // Serial data drive enable
  output reg sel_o, // Pulse: own address acknowledged
  output reg rw_o, // Direction of current transfer, 1 read
  output reg rx_stb_o, // Pulse: data byte received
  output reg [7:0] rx_byte_o, // Received data byte
  input wire [7:0] tx_byte_i, // Byte to send on next load
  output reg tx_load_o // Pulse: tx_byte_i consumed
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_AACK = 7'h04;
  localparam [6:0] S_RX = 7'h08;
  localparam [6:0] S_RACK = 7'h10;
  localparam [6:0] S_TX = 7'h20;
  localparam [6:0] S_MACK = 7'h40;

  reg scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  reg [6:0] state_reg;
  reg [7:0] sh_reg;
  reg [3:0] cnt_reg;
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_ev = scl_s & scl_p & ~sda_p & sda_s;

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      sda_oe_o <= 1'b0;
      sel_o <= 1'b0;
      rw_o <= 1'b0;
      rx_stb_o <= 1'b0;
      rx_byte_o <= 8'h00;
      tx_load_o <= 1'b0;
    end else begin
      sel_o <= 1'b0;
      rx_stb_o <= 1'b0;
      tx_load_o <= 1'b0;
      if (start_ev) begin
        state_reg <= S_ADDR;
        cnt_reg <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_ev) begin
        state_reg <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_reg)
          S_ADDR, S_RX: begin
            if (scl_rise && cnt_reg != 4'h8) begin
              sh_reg <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              if (state_reg == S_RX) begin
                rx_stb_o <= 1'b1;
                rx_byte_o <= sh_reg;
                sda_oe_o <= 1'b1;
                state_reg <= S_RACK;
              end else if (sh_reg[7:1] == DEV_ADDR) begin
                sel_o <= 1'b1;
                rw_o <= sh_reg[0];
                sda_oe_o <= 1'b1;
                state_reg <= S_AACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_AACK, S_MACK: begin
            if (state_reg == S_MACK && scl_rise && sda_s) begin
              state_reg <= S_IDLE;
            end else if (scl_fall && rw_o) begin
              // Upper byte goes out first in every pair
              sh_reg <= tx_byte_i;
              sda_oe_o <= ~tx_byte_i[7];
              tx_load_o <= 1'b1;
              cnt_reg <= 4'h1;
              state_reg <= S_TX;
            end else if (scl_fall) begin
              sda_oe_o <= 1'b0;
              cnt_reg <= 4'h0;
              state_reg <= S_RX;
            end
          end
          S_RACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              cnt_reg <= 4'h0;
              state_reg <= S_RX;
            end
          end
          S_TX: begin
            if (scl_fall && cnt_reg == 4'h8) begin
              sda_oe_o <= 1'b0;
              state_reg <= S_MACK;
            end else if (scl_fall) begin
              sh_reg <= {sh_reg[6:0], 1'b0};
              sda_oe_o <= ~sh_reg[6];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

//--- design/acm_top.v
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "acm_defs.vh"
module acm_top #(
  parameter [19:0] CYCLE_BASE = `ACM_CYCLE_BASE_CYC
) (
  input wire clock_i, // 250 MHz system clock
  input wire rst_i, // Async reset, active high
  input wire hsel_i, // AHB slave select
  input wire [31:0] haddr_i, // AHB address
  input wire [1:0] htrans_i, // AHB transfer type
  input wire hwrite_i, // AHB write, 1 write
  input wire [2:0] hsize_i, // AHB size, word only
  input wire [31:0] hwdata_i, // AHB write data
  input wire hready_i, // AHB bus ready
  output wire hreadyout_o, // AHB slave ready
  output wire hresp_o, // AHB response, always OKAY
  output reg [31:0] hrdata_o, // AHB read data
  input wire scl_i, // Serial clock pin
  input wire sda_i, // Serial data pin level
  output wire sda_o, // Serial data drive level
  output wire sda_oe_o, // Serial data drive enable
  output reg conv_start_o, // Pulse: start one conversion
  input wire conv_done_i, // Pulse: conversion finished
  input wire [9:0] conv_data_i, // Conversion result
  output reg osc_en_o, // Internal oscillator enable
  output reg alert_o // Out-of-range alert pin
);
  localparam [1:0] CS_IDLE = 2'b01;
  localparam [1:0] CS_BUSY = 2'b10;
  localparam integer QUIET_GAP_N = `ACM_QUIET_GAP_CYC;
  localparam [10:0] QUIET_GAP = QUIET_GAP_N[10:0];

  reg [9:0] result_reg;
  reg [1:0] status_reg;
  reg [7:0] config_reg;
  reg [9:0] lower_limit_reg;
  reg [9:0] upper_limit_reg;
  reg [9:0] hysteresis_amount_reg;
  reg [9:0] lowest_reading_reg;
  reg [9:0] highest_reading_reg;

  reg [1:0] cstate_reg;
  reg [19:0] itv_reg;
  reg [10:0] gap_reg;

  reg ahb_wr_reg;
  reg [2:0] ahb_idx_reg;
  reg ahb_in_map_reg;

  reg [2:0] ptr_reg;
  reg first_reg;
  reg lo_reg;
  reg [7:0] hi_byte_reg;
  reg tx_lo_reg;
  reg [15:0] snap_reg;

  wire lk_sel, lk_rw, lk_rx_stb, lk_tx_load;
  wire [7:0] lk_rx_byte;

  reg wr_en;
  reg [2:0] wr_idx;
  reg [15:0] wr_data;
  reg lk_wr;

  wire [2:0] cycle_time = config_reg[`ACM_CFG_CT_HI:`ACM_CFG_CT_LO];
  wire auto_mode = |cycle_time;
  wire busy = cstate_reg[1];
  wire conv_end = busy & conv_done_i;
  wire [19:0] itv_load = CYCLE_BASE << (cycle_time - 3'h1);
  wire quiet_hold = config_reg[`ACM_CFG_QUIET] & (gap_reg != 11'h000);
  wire byte_reg = (ptr_reg == `ACM_IDX_STATUS) ||
                  (ptr_reg == `ACM_IDX_CONFIG);
  wire ahb_accept = hsel_i & htrans_i[1] & hready_i;

  function [15:0] rd_word;
    input [2:0] idx;
    begin
      if (idx == `ACM_IDX_RESULT)
        rd_word = {6'h00, result_reg};
      else if (idx == `ACM_IDX_STATUS)
        rd_word = {14'h0000, status_reg};
      else if (idx == `ACM_IDX_CONFIG)
        rd_word = {8'h00, config_reg};
      else if (idx == `ACM_IDX_LOWER)
        rd_word = {6'h00, lower_limit_reg};
      else if (idx == `ACM_IDX_UPPER)
        rd_word = {6'h00, upper_limit_reg};
      else if (idx == `ACM_IDX_HYST)
        rd_word = {6'h00, hysteresis_amount_reg};
      else if (idx == `ACM_IDX_LOWEST)
        rd_word = {6'h00, lowest_reading_reg};
      else
        rd_word = {6'h00, highest_reading_reg};
    end
  endfunction

  wire [15:0] ptr_word = rd_word(ptr_reg);

  acm_link i_acm_link (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .sel_o(lk_sel),
    .rw_o(lk_rw),
    .rx_stb_o(lk_rx_stb),
    .rx_byte_o(lk_rx_byte),
    .tx_byte_i(tx_lo_reg ? snap_reg[7:0] : snap_reg[15:8]),
    .tx_load_o(lk_tx_load)
  );

  // A link write cannot wait, so an AHB write colliding with it stalls
  assign hreadyout_o = ~(ahb_wr_reg & lk_wr);
  assign hresp_o = 1'b0;

  // One write port shared by the link and the AHB slave
  always @* begin
    lk_wr = 1'b0;
    wr_data = 16'h0000;
    if (lk_rx_stb && !first_reg) begin
      if (byte_reg) begin
        lk_wr = ~lo_reg;
        wr_data = {8'h00, lk_rx_byte};
      end else begin
        lk_wr = lo_reg;
        wr_data = {hi_byte_reg, lk_rx_byte};
      end
    end
    wr_en = lk_wr;
    wr_idx = ptr_reg;
    if (!lk_wr && ahb_wr_reg && ahb_in_map_reg) begin
      wr_en = 1'b1;
      wr_idx = ahb_idx_reg;
      wr_data = hwdata_i[15:0];
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ahb_wr_reg <= 1'b0;
      ahb_idx_reg <= 3'h0;
      ahb_in_map_reg <= 1'b0;
      hrdata_o <= 32'h00000000;
    end else if (hready_i) begin
      ahb_wr_reg <= ahb_accept & hwrite_i;
      ahb_idx_reg <= haddr_i[4:2];
      ahb_in_map_reg <= haddr_i[31:5] == `ACM_AHB_MAP_TOP;
      if (ahb_accept && !hwrite_i) begin
        if (haddr_i[31:5] == `ACM_AHB_MAP_TOP)
          hrdata_o <= {16'h0000, rd_word(haddr_i[4:2])};
        else
          hrdata_o <= 32'h00000000;
      end
    end
  end

  // Link side: pointer, byte pairing and read snapshot
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg <= `ACM_IDX_RESULT;
      first_reg <= 1'b0;
      lo_reg <= 1'b0;
      hi_byte_reg <= 8'h00;
      tx_lo_reg <= 1'b0;
      snap_reg <= 16'h0000;
    end else begin
      if (lk_sel) begin
        first_reg <= ~lk_rw;
        lo_reg <= 1'b0;
        tx_lo_reg <= 1'b0;
        // One-byte registers repeat their value from the first byte on
        if (lk_rw && byte_reg)
          snap_reg <= {ptr_word[7:0], ptr_word[7:0]};
        else if (lk_rw)
          snap_reg <= ptr_word;
      end
      if (lk_rx_stb) begin
        if (first_reg) begin
          ptr_reg <= lk_rx_byte[2:0];
          first_reg <= 1'b0;
        end else begin
          hi_byte_reg <= lk_rx_byte;
          lo_reg <= ~lo_reg;
        end
      end
      if (lk_tx_load) begin
        if (byte_reg) begin
          snap_reg <= {ptr_word[7:0], ptr_word[7:0]};
        end else if (tx_lo_reg) begin
          // Fresh snapshot for the next pair
          snap_reg <= ptr_word;
          tx_lo_reg <= 1'b0;
        end else begin
          tx_lo_reg <= 1'b1;
        end
      end
    end
  end

  // Periodic conversion control
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cstate_reg <= CS_IDLE;
      itv_reg <= 20'h00000;
      gap_reg <= 11'h000;
      conv_start_o <= 1'b0;
      osc_en_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      osc_en_o <= auto_mode | busy;
      if (gap_reg != 11'h000)
        gap_reg <= gap_reg - 11'h001;
      if (!auto_mode)
        itv_reg <= 20'h00000;
      else if (itv_reg != 20'h00000)
        itv_reg <= itv_reg - 20'h00001;
      case (cstate_reg)
        CS_IDLE: begin
          // Quiet reading spaces starts at least one gap apart
          if (auto_mode && itv_reg == 20'h00000 && !quiet_hold) begin
            conv_start_o <= 1'b1;
            cstate_reg <= CS_BUSY;
            itv_reg <= itv_load - 20'h00001;
            gap_reg <= QUIET_GAP - 11'h001;
          end
        end
        CS_BUSY: begin
          if (conv_done_i)
            cstate_reg <= CS_IDLE;
        end
        default: begin
          cstate_reg <= CS_IDLE;
        end
      endcase
    end
  end

  // Register file, result handling and alert evaluation
  reg over_set, under_set, over_hclr, under_hclr;
  reg [10:0] up_band, low_band;
  reg [1:0] w1c;
  always @* begin
    up_band = {1'b0, upper_limit_reg} - {1'b0, hysteresis_amount_reg};
    low_band = {1'b0, lower_limit_reg} + {1'b0, hysteresis_amount_reg};
    over_set = conv_end & config_reg[`ACM_CFG_FLAG_EN] &
               (conv_data_i > upper_limit_reg);
    under_set = conv_end & config_reg[`ACM_CFG_FLAG_EN] &
                (conv_data_i < lower_limit_reg);
    over_hclr = conv_end & ~config_reg[`ACM_CFG_HOLD] & ~up_band[10] &
                ({1'b0, conv_data_i} < up_band);
    under_hclr = conv_end & ~config_reg[`ACM_CFG_HOLD] &
                 ({1'b0, conv_data_i} > low_band);
    w1c = (wr_en && wr_idx == `ACM_IDX_STATUS) ? wr_data[1:0] : 2'b00;
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      result_reg <= 10'h000;
      status_reg <= 2'b00;
      config_reg <= `ACM_RST_CONFIG;
      lower_limit_reg <= `ACM_RST_LOWER;
      upper_limit_reg <= `ACM_RST_UPPER;
      hysteresis_amount_reg <= `ACM_RST_HYST;
      lowest_reading_reg <= `ACM_RST_LOWEST;
      highest_reading_reg <= `ACM_RST_HIGHEST;
    end else begin
      if (conv_end)
        result_reg <= conv_data_i;
      // A new violation wins over a clear in the same cycle
      status_reg[`ACM_ST_OVER] <= over_set |
        (status_reg[`ACM_ST_OVER] & ~w1c[`ACM_ST_OVER] & ~over_hclr);
      status_reg[`ACM_ST_UNDER] <= under_set |
        (status_reg[`ACM_ST_UNDER] & ~w1c[`ACM_ST_UNDER] & ~under_hclr);
      if (wr_en && wr_idx == `ACM_IDX_CONFIG)
        config_reg <= wr_data[7:0];
      if (wr_en && wr_idx == `ACM_IDX_LOWER)
        lower_limit_reg <= wr_data[9:0];
      if (wr_en && wr_idx == `ACM_IDX_UPPER)
        upper_limit_reg <= wr_data[9:0];
      if (wr_en && wr_idx == `ACM_IDX_HYST)
        hysteresis_amount_reg <= wr_data[9:0];
      if (wr_en && wr_idx == `ACM_IDX_LOWEST)
        lowest_reading_reg <= wr_data[9:0];
      else if (conv_end && conv_data_i < lowest_reading_reg)
        lowest_reading_reg <= conv_data_i;
      if (wr_en && wr_idx == `ACM_IDX_HIGHEST)
        highest_reading_reg <= wr_data[9:0];
      else if (conv_end && conv_data_i > highest_reading_reg)
        highest_reading_reg <= conv_data_i;
    end
  end

  // Pin polarity bit picks active high or active low
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      alert_o <= 1'b1;
    else
      alert_o <= ~config_reg[`ACM_CFG_POL] ^
        (config_reg[`ACM_CFG_PIN_EN] & (|status_reg));
  end
endmodule

//--- verif/acm_top_monitor.sv
`timescale 1ns/1ps
module acm_top_checker #(
  parameter [19:0] CYCLE_BASE = 20'd50
) (
  input wire clock_i, // System clock
  input wire rst_i, // Async reset
  input wire hsel_i, // Slave select
  input wire [1:0] htrans_i, // Transfer type
  input wire hwrite_i, // Write strobe
  input wire hready_i, // Bus ready
  input wire hreadyout_o, // Slave ready
  input wire hresp_o, // Response
  input wire [31:0] hrdata_o, // Read data
  input wire scl_i, // Serial clock
  input wire sda_oe_o, // Data drive enable
  input wire conv_start_o, // Conversion start
  input wire conv_done_i, // Conversion done
  input wire osc_en_o, // Oscillator enable
  input wire alert_o // Alert pin
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [2:0] quiet_cnt;
  // Alert may also move after register writes, so only judge quiet spans
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_cnt <= 3'h0;
    end else if (hsel_i || sda_oe_o) begin
      quiet_cnt <= 3'h0;
    end else if (quiet_cnt != 3'h7) begin
      quiet_cnt <= quiet_cnt + 3'h1;
    end
  end
  property p_osc;
    conv_start_o |-> osc_en_o;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator off at start");
  property p_pulse;
    conv_start_o |=> !conv_start_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start not a pulse");
  property p_one;
    conv_start_o |=> (!conv_start_o until conv_done_i);
  endproperty
  a_one: assert property (p_one) else $error("second start too early");
  property p_alert;
    $changed(alert_o) && quiet_cnt > 3'h4 |-> $past(conv_done_i, 2);
  endproperty
  a_alert: assert property (p_alert) else $error("alert moved alone");
  property p_wait;
    !hreadyout_o |=> hreadyout_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait too long");
  property p_rdata;
    $changed(hrdata_o) |-> $past(hsel_i && htrans_i[1] && hready_i
      && !hwrite_i);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_sda;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_sda: assert property (p_sda) else $error("data moved, clock high");
  property p_hresp;
    hresp_o == 1'b0 && hrdata_o[31:16] == 16'h0000;
  endproperty
  a_hresp: assert property (p_hresp) else $error("bad response");
  c_start: cover property (conv_start_o);
  c_alert: cover property ($rose(alert_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_wait: cover property (!hreadyout_o);
endmodule

bind acm_top acm_top_checker #(.CYCLE_BASE(CYCLE_BASE)) i_acm_top_checker (
  .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .hrdata_o(hrdata_o), .scl_i(scl_i),
  .sda_oe_o(sda_oe_o), .conv_start_o(conv_start_o),
  .conv_done_i(conv_done_i), .osc_en_o(osc_en_o), .alert_o(alert_o));

//--- verif/acm_i2c_host.sv
`timescale 1ns/1ps
module acm_i2c_host (
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Serial clock, high when released
  output logic pull_o // High pulls the data line low
);
  logic slow;
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
    slow = 1'b0;
  end
  // One 160 ns bit; data only moves while the clock is low
  task automatic clk_bit(input logic b, output logic r);
    pull_o = ~b;
    #40 scl_o = 1'b1;
    #40 r = sda_i;
    // Quiet reading keeps the clock released well over 1 us per bit
    if (slow) #1000;
    #40 scl_o = 1'b0;
    #40;
  endtask
  task automatic start();
    pull_o = 1'b1;
    #40 scl_o = 1'b0;
    #40;
  endtask
  // Clock rests high after the frame
  task automatic stop();
    pull_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 pull_o = 1'b0;
    #80;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, ack);
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(last, r);
  endtask
  // Pointer load always comes first, before any read elsewhere
  task automatic set_ptr(input logic [6:0] dev, input logic [7:0] p,
    output logic ack);
    logic a0;
    start();
    put({dev, 1'b0}, a0);
    put(p, ack);
    ack = ack | a0;
    stop();
  endtask
  task automatic read_word(input logic [6:0] dev, input logic q,
    output logic [15:0] w);
    logic a;
    start();
    slow = q;
    put({dev, 1'b1}, a);
    get(1'b0, w[15:8]);
    get(1'b1, w[7:0]);
    slow = 1'b0;
    stop();
  endtask
  // Pointer byte first, then one or two data bytes
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p,
    input logic [15:0] d, input logic two, output logic ack);
    logic a0, a1, a2;
    start();
    put({dev, 1'b0}, a0);
    put(p, a1);
    put(d[15:8], a2);
    ack = a0 | a1 | a2;
    if (two) begin
      put(d[7:0], a2);
      ack = ack | a2;
    end
    stop();
  endtask
endmodule

//--- verif/acm_top_bench.sv
`timescale 1ns/1ps
`include "acm_defs.vh"
module acm_top_bench;
  localparam int BASE = 50;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic conv_done_i = 1'b0;
  logic [9:0] conv_data_i = 10'h000;
  logic [9:0] vin = 10'h200;
  wire hreadyout_o, hresp_o, sda_o, sda_oe_o, conv_start_o;
  wire osc_en_o, alert_o, scl, pull, sda;
  wire [31:0] hrdata_o;
  int lat = 3;
  int cyc, t0, gap, starts, mismatches, checks;
  logic [31:0] rd;
  logic [15:0] w;
  logic ack, done;
  logic [31:0] rst_tab [8] = '{32'h0, 32'h0, `ACM_RST_CONFIG,
    `ACM_RST_LOWER, `ACM_RST_UPPER, `ACM_RST_HYST, `ACM_RST_LOWEST,
    `ACM_RST_HIGHEST};
  assign sda = ~(sda_oe_o | pull);
  always #2 clock_i = ~clock_i;
  acm_top #(.CYCLE_BASE(20'd50)) i_acm_top (.clock_i(clock_i),
    .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .conv_start_o(conv_start_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .osc_en_o(osc_en_o), .alert_o(alert_o));
  acm_i2c_host i_acm_i2c_host (.sda_i(sda), .scl_o(scl), .pull_o(pull));
  always @(posedge clock_i) cyc <= cyc + 1;
  // Converter model; data is scrambled outside the done pulse
  always @(posedge clock_i) begin
    if (conv_start_o === 1'b1) begin
      gap = cyc - t0;
      t0 = cyc;
      starts++;
      repeat (lat) @(posedge clock_i);
      conv_done_i <= 1'b1;
      conv_data_i <= vin;
      @(posedge clock_i);
      conv_done_i <= 1'b0;
      conv_data_i <= ~vin;
    end
  end
  function automatic [31:0] ra(input logic [2:0] i);
    return {27'h0, i, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready and read data are sampled mid-cycle, settled before the edge
  task automatic ahb(input logic wr, input logic [31:0] a, d);
    logic ok;
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    do begin
      @(negedge clock_i) ok = hreadyout_o;
      @(posedge clock_i);
    end while (ok !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do begin
      @(negedge clock_i) ok = hreadyout_o;
      rd = hrdata_o;
      @(posedge clock_i);
    end while (ok !== 1'b1);
  endtask
  task automatic rchk(input logic [2:0] i, input logic [31:0] exp);
    ahb(1'b0, ra(i), 32'h0);
    chk(rd, exp);
  endtask
  // Waits for n more starts, then for the result and alert to land
  task automatic convs(input int n);
    int s;
    s = starts + n;
    for (int i = 0; i < 20000 && starts < s; i++) @(posedge clock_i);
    if (starts < s) mismatches++;
    repeat (lat + 3) @(posedge clock_i);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (int i = 0; i < 8; i++) rchk(i[2:0], rst_tab[i]);
    ahb(1'b1, ra(`ACM_IDX_RESULT), 32'h155);
    ahb(1'b1, 32'h20, 32'h155);
    ahb(1'b0, 32'h20, 32'h0);
    chk(rd, 32'h0);
    repeat (300) @(posedge clock_i);
    rchk(`ACM_IDX_RESULT, 32'h0);
    chk(starts, 0);
    ahb(1'b1, ra(`ACM_IDX_LOWER), 32'h100);
    ahb(1'b1, ra(`ACM_IDX_UPPER), 32'h300);
    ahb(1'b1, ra(`ACM_IDX_HYST), 32'h010);
    ahb(1'b1, ra(`ACM_IDX_CONFIG), 32'h2d);
    convs(2);
    chk(gap, BASE);
    rchk(`ACM_IDX_RESULT, 32'h200);
    rchk(`ACM_IDX_STATUS, 32'h0);
    rchk(`ACM_IDX_LOWEST, 32'h200);
    rchk(`ACM_IDX_HIGHEST, 32'h200);
    chk(alert_o, 1'b0);
    chk(osc_en_o, 1'b1);
    vin = 10'h350;
    lat = 20;
    convs(1);
    rchk(`ACM_IDX_STATUS, 32'h2);
    chk(alert_o, 1'b1);
    rchk(`ACM_IDX_HIGHEST, 32'h350);
    ahb(1'b1, ra(`ACM_IDX_STATUS), 32'h2);
    convs(1);
    rchk(`ACM_IDX_STATUS, 32'h2);
    vin = 10'h2f8;
    convs(1);
    rchk(`ACM_IDX_STATUS, 32'h2);
    vin = 10'h080;
    convs(1);
    rchk(`ACM_IDX_STATUS, 32'h1);
    rchk(`ACM_IDX_LOWEST, 32'h080);
    ahb(1'b1, ra(`ACM_IDX_CONFIG), 32'h6d);
    convs(3);
    chk(gap, BASE * 4);
    ahb(1'b1, ra(`ACM_IDX_CONFIG), 32'h2f);
    convs(2);
    chk(gap >= 1544, 1);
    ahb(1'b1, ra(`ACM_IDX_CONFIG), 32'h00);
    repeat (40) @(posedge clock_i);
    t0 = starts;
    repeat (400) @(posedge clock_i);
    chk(starts, t0);
    chk(osc_en_o, 1'b0);
    rchk(`ACM_IDX_HIGHEST, 32'h350);
    ahb(1'b1, ra(`ACM_IDX_LOWEST), 32'h3ff);
    rchk(`ACM_IDX_LOWEST, 32'h3ff);
    i_acm_i2c_host.set_ptr(`ACM_DEV_ADDR, 8'h07, ack);
    chk(ack, 1'b0);
    i_acm_i2c_host.read_word(`ACM_DEV_ADDR, 1'b0, w);
    chk(w, 16'h0350);
    i_acm_i2c_host.read_word(`ACM_DEV_ADDR, 1'b0, w);
    chk(w, 16'h0350);
    i_acm_i2c_host.set_ptr(`ACM_DEV_ADDR, 8'h00, ack);
    i_acm_i2c_host.read_word(`ACM_DEV_ADDR, 1'b0, w);
    chk(w, 16'h0080);
    // Bus writes run against link writes, shifted so one round collides
    for (int k = 0; k < 2; k++) begin
      done = 1'b0;
      @(posedge clock_i);
      fork
        begin
          i_acm_i2c_host.write_reg(`ACM_DEV_ADDR, 8'h04, 16'h0123, 1'b1,
            ack);
          done = 1'b1;
        end
        begin
          repeat (k) @(posedge clock_i);
          while (!done) ahb(1'b1, ra(`ACM_IDX_LOWER), 32'h155);
        end
      join
      chk(ack, 1'b0);
    end
    rchk(`ACM_IDX_UPPER, 32'h123);
    rchk(`ACM_IDX_LOWER, 32'h155);
    i_acm_i2c_host.read_word(`ACM_DEV_ADDR, 1'b0, w);
    chk(w, 16'h0123);
    i_acm_i2c_host.write_reg(`ACM_DEV_ADDR, 8'h02, 16'h0d00, 1'b0, ack);
    chk(ack, 1'b0);
    i_acm_i2c_host.read_word(`ACM_DEV_ADDR, 1'b1, w);
    chk(w, 16'h0d0d);
    rchk(`ACM_IDX_CONFIG, 32'h0d);
    chk(sda_o, 1'b0);
    @(posedge clock_i);
    results();
  end
endmodule
